// File: logic/stn_trap_regs.vh
// constants for the software trap / non-maskable interrupt unit
`ifndef STN_TRAP_REGS_VH
`define STN_TRAP_REGS_VH

// ****************************************
// opcodes and vector offsets
// ****************************************
`define STN_OP_TRAP         8'h00
`define STN_OP_CLRPND       8'h3D
`define STN_OP_VIS          8'hB4
`define STN_OP_INTERRUPT_RETURN_INSTR         8'h8F
`define STN_OP_RET          8'h8E
`define STN_OP_RETURN_AND_SKIP_INSTR        8'h8D
`define STN_VEC_TRAP        8'hFE
`define STN_VEC_EXT         8'hFA
`define STN_VEC_DEFAULT     8'hE0
`define STN_VEC_HI_OFS      8'hFE
`define STN_VEC_LO_OFS      8'hFF

// ****************************************
// stack and memory limits
// ****************************************
`define STN_STACK_LIMIT     12'h06F
`define STN_PC_LAST         15'h7FFF
`define STN_PROG_SIZE       16'h8000

// ****************************************
// status register fields and reset value
// ****************************************
`define STN_PSW_GIE         0
`define STN_PSW_EXT_IRQ_ENABLE        1
`define STN_PSW_EXT_IRQ_PENDING       3
`define STN_PSW_RESET       8'h00

// ****************************************
// sideband register port offsets
// ****************************************
`define STN_ADDR_PSW        4'h0
`define STN_ADDR_STATUS     4'h1

`endif

// File: logic/stn_vector_arb.v
// vector arbitration for the vector-select instruction
`timescale 1ns/1ps
`include "stn_trap_regs.vh"

module stn_vector_arb
(
    input  wire       trapPend,
    input  wire       extReq,
    output reg  [7:0] vecLow,
    output reg        maskBlocked
);

    // trap first, then external, then the default slot
    always @*
    begin
        maskBlocked = trapPend;
        if (trapPend)
            vecLow = `STN_VEC_TRAP;
        else if (extReq)
            vecLow = `STN_VEC_EXT;
        else
            vecLow = `STN_VEC_DEFAULT;
    end

endmodule // stn_vector_arb

// File: logic/stn_trap_unit.v
// software trap and external interrupt control inside the cpu interrupt unit
`timescale 1ns/1ps
`include "stn_trap_regs.vh"

module stn_trap_unit
(
    input  wire        clk,
    input  wire        rstn,
    // fetch and decode side
    input  wire        irLoad,
    input  wire [7:0]  fetchByte,
    input  wire        fetchValid,
    input  wire [14:0] opAddr,
    input  wire        execValid,
    input  wire [7:0]  execOp,
    input  wire [14:0] stackRetAddr,
    input  wire [11:0] stackPtr,
    input  wire        stackPop,
    input  wire [14:0] vectorWord,
    // external interrupt request pin
    input  wire        extPin,
    // register port
    input  wire [3:0]  regAddr,
    input  wire [7:0]  regWrData,
    input  wire        regWr,
    input  wire        regRd,
    output reg  [7:0]  regRdData,
    // cpu control outputs
    output reg  [7:0]  irByte,
    output reg         trapTaken,
    output reg  [14:0] pushAddr,
    output reg         pushValid,
    output reg         pcLoad,
    output reg  [14:0] pcValue,
    output reg  [7:0]  visLow,
    output reg         irqAccept,
    output reg         trapPending
);

    // ****************************************
    // state
    // ****************************************
    reg         trapFlag;
    reg  [7:0]  processor_status_reg;
    reg         extSync1;
    reg         extSync2;
    reg         extLast;
    wire [7:0]  vecLow;
    wire        maskBlocked;
    wire [7:0]  decodedByte;
    wire        isTrap;
    wire        isClear;
    wire        isReti;
    wire        isVis;
    wire        extReq;
    wire        stackUnder;
    wire        extEdge;

    // absent memory reads as zero, which decodes as a trap
    assign decodedByte = fetchValid ? fetchByte : `STN_OP_TRAP;
    assign isTrap      = irLoad && (decodedByte == `STN_OP_TRAP);
    assign isClear     = execValid && (execOp == `STN_OP_CLRPND);
    assign isReti      = execValid && (execOp == `STN_OP_INTERRUPT_RETURN_INSTR);
    assign isVis       = execValid && (execOp == `STN_OP_VIS);
    assign stackUnder  = stackPop && (stackPtr > `STN_STACK_LIMIT);
    assign extEdge     = extSync2 && !extLast;

    // external source needs its enable and the global enable
    assign extReq = processor_status_reg[`STN_PSW_EXT_IRQ_PENDING] && processor_status_reg[`STN_PSW_EXT_IRQ_ENABLE]
                    && processor_status_reg[`STN_PSW_GIE];

    stn_vector_arb u_arb
    (
        .trapPend    (trapFlag),
        .extReq      (extReq),
        .vecLow      (vecLow),
        .maskBlocked (maskBlocked)
    );

    // ****************************************
    // pin synchroniser
    // ****************************************
    // two stages before the edge detector sees the pin
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            extSync1 <= 1'b0;
            extSync2 <= 1'b0;
            extLast  <= 1'b0;
        end
        else
        begin
            extSync1 <= extPin;
            extSync2 <= extSync1;
            extLast  <= extSync2;
        end
    end

    // ****************************************
    // trap pending flag
    // ****************************************
    // no register address reaches this flag; only decode and clear touch it.
    // a trap in the same cycle as a clear wins so the event is not lost.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            trapFlag <= 1'b0;
        else if (isTrap)
            trapFlag <= 1'b1;
        else if (isClear)
            trapFlag <= 1'b0;
    end

    // ****************************************
    // status register
    // ****************************************
    // the trap never writes the global enable; acceptance and return do
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            processor_status_reg <= `STN_PSW_RESET;
        else
        begin
            if (regWr && regAddr == `STN_ADDR_PSW)
                processor_status_reg <= regWrData;
            if (extEdge)
                processor_status_reg[`STN_PSW_EXT_IRQ_PENDING] <= 1'b1;                   // set beats clear
            if (isReti)
                processor_status_reg[`STN_PSW_GIE] <= 1'b1;
            else if (extReq && !maskBlocked && !isTrap)
                processor_status_reg[`STN_PSW_GIE] <= 1'b0;
        end
    end

    // ****************************************
    // cpu control outputs
    // ****************************************
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            irByte      <= 8'h00;
            trapTaken   <= 1'b0;
            pushAddr    <= 15'h0000;
            pushValid   <= 1'b0;
            pcLoad      <= 1'b0;
            pcValue     <= 15'h0000;
            visLow      <= 8'h00;
            irqAccept   <= 1'b0;
            trapPending <= 1'b0;
        end
        else
        begin
            trapPending <= isTrap | (trapFlag & ~isClear);
            if (irLoad)
                irByte <= decodedByte;
            trapTaken <= isTrap;
            // the return address is the trap opcode itself
            pushValid <= isTrap || (extReq && !maskBlocked && !isTrap);
            pushAddr  <= opAddr;
            // maskable acceptance is held off while a trap is pending
            irqAccept <= extReq && !maskBlocked && !isTrap;
            if (isVis)
                visLow <= vecLow;
            if (stackUnder)
            begin
                pcLoad  <= 1'b1;
                pcValue <= `STN_PC_LAST;
            end
            else if (isReti)
            begin
                pcLoad  <= 1'b1;
                pcValue <= stackRetAddr;
            end
            else if (isVis)
            begin
                pcLoad  <= 1'b1;
                pcValue <= vectorWord;
            end
            else
                pcLoad  <= 1'b0;
        end
    end

    // ****************************************
    // register read port
    // ****************************************
    // the trap flag is deliberately absent from the readable map
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            regRdData <= 8'h00;
        else if (regRd)
        begin
            case (regAddr)
                `STN_ADDR_PSW:    regRdData <= processor_status_reg;
                `STN_ADDR_STATUS: regRdData <= {7'h00, extSync2};
                default:          regRdData <= 8'h00;
            endcase
        end
        else
            regRdData <= 8'h00;
    end

endmodule // stn_trap_unit

// File: testbench/stn_trap_chk.sv
// assertion checker for the software trap unit
`timescale 1ns/1ps
module stn_trap_chk
(
    input logic        clk,
    input logic        rstn,
    input logic        irLoad,
    input logic [7:0]  fetchByte,
    input logic        fetchValid,
    input logic [14:0] opAddr,
    input logic        execValid,
    input logic [7:0]  execOp,
    input logic [14:0] vectorWord,
    input logic        stackPop,
    input logic [11:0] stackPtr,
    input logic        trapTaken,
    input logic [14:0] pushAddr,
    input logic        pushValid,
    input logic        pcLoad,
    input logic [14:0] pcValue,
    input logic [7:0]  visLow,
    input logic        irqAccept,
    input logic        trapPending
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // ****
    // trap entry and clear
    // ****
    // absent memory reads as the trap opcode
    sequence trapSeen;
        irLoad && (!fetchValid || fetchByte == 8'h00);
    endsequence
    sequence clrSeen;
        execValid && execOp == 8'h3d;
    endsequence
    trap_entry_a: assert property (
        trapSeen |=> trapTaken && pushValid && trapPending && pushAddr == $past(opAddr))
        else $error("trap entry wrong");
    trap_rise_a: assert property (
        $rose(trapPending) |-> $past(irLoad && (!fetchValid || fetchByte == 8'h00)))
        else $error("pending set without trap");
    clear_effect_a: assert property (
        clrSeen |=> !trapPending || $past(irLoad)) else $error("clear ignored");
    clear_only_a: assert property (
        $fell(trapPending) |-> $past(execValid && execOp == 8'h3d))
        else $error("pending dropped without clear");
    taken_pend_a: assert property (
        trapTaken |-> trapPending) else $error("taken without pending");
    irq_block_a: assert property (
        irqAccept |-> !trapPending) else $error("irq accepted while pending");
    vis_trap_a: assert property (
        execValid && execOp == 8'hb4 && trapPending
        |=> visLow == 8'hfe && pcLoad && pcValue == $past(vectorWord))
        else $error("vis not steered to trap");
    stack_under_a: assert property (
        stackPop && stackPtr > 12'h006f |=> pcLoad && pcValue == 15'h7fff)
        else $error("underflow pc wrong");
endmodule // stn_trap_chk

bind stn_trap_unit stn_trap_chk u_chk (.*);

// File: testbench/stn_cpu_model.sv
// behavioural model of the cpu stack and vector memory
`timescale 1ns/1ps
module stn_cpu_model
(
    input  logic        clk,
    input  logic        rstn,
    input  logic        pushValid,
    input  logic [14:0] pushAddr,
    input  logic        stackPop,
    input  logic        trapPending,
    output logic [14:0] vectorWord,
    output logic [14:0] stackRetAddr
);
    logic [14:0] stk [0:7];
    logic [2:0]  sp;
    // ****
    // vector table and stack
    // ****
    // trap slot bytes 03,10 high byte first; other slot is a dummy
    assign vectorWord = trapPending ? 15'h0310 : 15'h0240;
    // small stack; wraps silently, the unit guards the real limit
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            sp <= 3'h0;
        else if (pushValid)
        begin
            stk[sp] <= pushAddr;
            sp <= sp + 3'h1;
        end
        else if (stackPop)
            sp <= sp - 3'h1;
    end
    assign stackRetAddr = stk[sp - 3'h1];
endmodule // stn_cpu_model

// File: testbench/tb_top.sv
// self-checking bench for the software trap unit
`timescale 1ns/1ps
module tb_top;
    logic        clk, rstn, irLoad, fetchValid, execValid, stackPop, extPin, regWr, regRd;
    logic        trapTaken, pushValid, pcLoad, irqAccept, trapPending;
    logic [7:0]  fetchByte, execOp, regWrData, regRdData, irByte, visLow;
    logic [14:0] opAddr, stackRetAddr, vectorWord, pushAddr, pcValue;
    logic [11:0] stackPtr;
    logic [3:0]  regAddr;
    int          num_errors = 0, n_checks = 0, nAcc = 0, i;
    stn_trap_unit dut (.*);
    stn_cpu_model cpu (.*);
    // ****
    // clock and helpers
    // ****
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // sticky count so short accept pulses are never missed
    always @(posedge clk) if (irqAccept === 1'b1) nAcc <= nAcc + 1;
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (e !== g)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic fetch(input logic [7:0] b, input logic v, input logic [14:0] a);
        @(posedge clk);
        irLoad <= 1'b1;
        fetchByte <= b;
        fetchValid <= v;
        opAddr <= a;
        @(posedge clk);
        irLoad <= 1'b0;
        #1;
    endtask
    task automatic exec(input logic [7:0] op);
        @(posedge clk);
        execValid <= 1'b1;
        execOp <= op;
        @(posedge clk);
        execValid <= 1'b0;
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ****
    // main sequence
    // ****
    initial
    begin
        {irLoad, fetchValid, execValid, stackPop, extPin, regWr, regRd} = '0;
        {fetchByte, execOp, regWrData, opAddr, stackPtr, regAddr} = '0;
        rstn = 1'b0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        cyc(1);
        chk("pending after reset", 0, trapPending);
        rd(4'h0);
        chk("status reset", 8'h00, regRdData);
        exec(8'h3d);
        chk("idle clear", 0, {trapPending, pushValid, pcLoad});
        wr(4'h0, 8'h03);
        fetch(8'h00, 1'b1, 15'h1234);
        chk("trap taken", 3'h7, {trapTaken, pushValid, trapPending});
        chk("return addr", 15'h1234, pushAddr);
        rd(4'h0);
        chk("enable kept", 8'h03, regRdData);
        rd(4'hf);
        chk("unmapped", 8'h00, regRdData);
        nAcc = 0;
        extPin <= 1'b1;
        cyc(8);
        chk("masked irq", 0, nAcc);
        exec(8'hb4);
        chk("vis low", 8'hfe, visLow);
        chk("vis pc", 15'h0310, pcValue);
        exec(8'h8e);
        exec(8'h8f);
        chk("still pending", 1, trapPending);
        fetch(8'hff, 1'b0, 15'h7ffe);
        chk("absent trap", 2'h3, {trapTaken, trapPending});
        chk("ir byte", 8'h00, irByte);
        rd(4'h1);
        chk("pin status", 8'h01, regRdData);
        // software clears first and then returns with skip
        exec(8'h3d);
        chk("cleared", 0, trapPending);
        exec(8'h8d);
        for (i = 0; i < 20 && nAcc == 0; i++) cyc(1);
        chk("irq after clear", 1, nAcc != 0);
        if (nAcc == 0) close_out();
        rd(4'h0);
        chk("enable off", 0, regRdData[0]);
        // service routine drops the external pending bit before returning
        wr(4'h0, 8'h02);
        exec(8'h8f);
        chk("interrupt_return_instr pc", 15'h7ffe, pcValue);
        rd(4'h0);
        chk("enable back", 1, regRdData[0]);
        wr(4'h0, 8'h02);
        extPin <= 1'b0;
        cyc(3);
        nAcc = 0;
        extPin <= 1'b1;
        cyc(8);
        chk("global gate", 0, nAcc);
        @(posedge clk);
        stackPop <= 1'b1;
        stackPtr <= 12'h0070;
        @(posedge clk);
        stackPop <= 1'b0;
        #1;
        chk("underflow pc", 16'hffff, {pcLoad, pcValue});
        fetch(8'h00, 1'b0, 15'h7fff);
        chk("last addr trap", 1, trapPending);
        // recovery restarts from a known point rather than returning
        rstn <= 1'b0;
        cyc(2);
        chk("reset clears", 0, trapPending);
        close_out();
    end
endmodule // tb_top
